/* File: common/acqd_consts.svh */
// constants for the acquisition dma block
`ifndef ACQD_CONSTS_SVH
`define ACQD_CONSTS_SVH
`define ACQD_NCHAN 4
`define ACQD_SAMPLE_W 16
`define ACQD_SRC_W 3
`define ACQD_SRC_TEST 3'h4
`define ACQD_SRC_LOOP 3'h5
`define ACQD_LEN_W 32
`define ACQD_TS_W 48
`define ACQD_FIFO_DEPTH 8
`define ACQD_BANK_ADDR_W 29
`define ACQD_LINKS 64
`define ACQD_LINK_W 6
`define ACQD_CLKMON_NS 64
`define ACQD_CLK_PERIOD_NS 8
`define ACQD_CLKMON_CYC (`ACQD_CLKMON_NS / `ACQD_CLK_PERIOD_NS)
`define ACQD_OVL_MAX 16'h7FFF
`define ACQD_OVL_MIN 16'h8000
`define ACQD_OVL_HOLD 8'hFF
`endif

/* File: common/acqd_pkg.sv */
// types shared by the acquisition dma block
package acqd_pkg;
   typedef struct packed {
      logic [1:0] chan;
      logic [47:0] stamp;
      logic [31:0] length;
   } acqd_meta_s;
   typedef struct packed {
      logic [31:0] length;
      logic gate_mode;
      logic last;
   } acqd_link_s;
   typedef struct packed {
      logic clk;
      logic sync;
      logic gate;
   } acqd_tbus_s;
   typedef enum logic [1:0] {
      ACQD_IDLE = 2'b00,
      ACQD_HEAD = 2'b01,
      ACQD_DATA = 2'b10,
      ACQD_CLOSE = 2'b11
   } acqd_state_e;
endpackage : acqd_pkg

/* File: core/acqd_fifo.sv */
// parameterised valid/ready fifo
`timescale 1ns/100ps
module acqd_fifo #(
   parameter int WIDTH = 16,
   parameter int DEPTH = 8
) (
   // clock and reset
   input wire logic clk,
   input wire logic rstn,
   // fill side
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [WIDTH-1:0] in_data,
   // drain side
   output logic out_valid,
   input wire logic out_ready,
   output logic [WIDTH-1:0] out_data
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW:0] wr_reg;
   logic [AW:0] rd_reg;
   logic full;
   logic empty;
   assign empty = (wr_reg == rd_reg);
   assign full = (wr_reg[AW] != rd_reg[AW]) &&
      (wr_reg[AW-1:0] == rd_reg[AW-1:0]);
   assign in_ready = !full;
   assign out_valid = !empty;
   assign out_data = mem[rd_reg[AW-1:0]];
   always_ff @(posedge clk) begin
      if (in_valid && !full) begin
         mem[wr_reg[AW-1:0]] <= in_data;
      end
   end
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         wr_reg <= '0;
      end else if (in_valid && !full) begin
         wr_reg <= wr_reg + 1'b1;
      end
   end
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         rd_reg <= '0;
      end else if (out_ready && !empty) begin
         rd_reg <= rd_reg + 1'b1;
      end
   end
endmodule : acqd_fifo

/* File: core/acqd_sync.sv */
// two-flop synchroniser for a bus of levels
`timescale 1ns/100ps
module acqd_sync #(
   parameter int WIDTH = 1
) (
   // clock and reset
   input wire logic clk,
   input wire logic rstn,
   // levels
   input wire logic [WIDTH-1:0] d,
   output logic [WIDTH-1:0] q
);
   logic [WIDTH-1:0] meta_reg;
   logic [WIDTH-1:0] q_reg;
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         meta_reg <= '0;
         q_reg <= '0;
      end else begin
         meta_reg <= d;
         q_reg <= meta_reg;
      end
   end
   assign q = q_reg;
endmodule : acqd_sync

/* File: core/acqd_channel.sv */
// one acquisition channel with linked-list dma toward the host
//
// Summary of operation
// R1 - the source selector picks a converter, the test pattern or loopback.
// R2 - the bank runs as a continuous fifo or as a transient capture store.
// R3 - a dma engine drains the bank toward the host over the pcie stream.
// R4 - the engine walks a chain of links without software between them.
// R5 - in gate mode a link runs exactly as long as the gate stays high.
// R6 - each transfer gets a header with channel id, sample stamp and length.
// R7 - each bank is a one gigabyte fifo where outgoing packets are built; here the bank is FIFO_DEPTH words deep, 8 by default.
// R8 - two timing buses go out, each with clock, sync and gate or trigger.
// R9 - an outside system may drive one timing input as gate, trigger or sync; here it drives gate only, sync has its own pin sync_in.
// R10 - each of the four converter inputs has its own overload indication.
// R11 - clock present shows a seen sample clock; without it no samples taken.
// R12 - on gate fall in gate mode the link closes, keeps its length, moves on.
`timescale 1ns/100ps
`include "acqd_consts.svh"
module acqd_channel #(
   parameter logic [1:0] CHAN_ID = 2'h0,
   parameter int FIFO_DEPTH = `ACQD_FIFO_DEPTH,
   parameter int LINKS = `ACQD_LINKS
) (
   // clock and reset
   input wire logic clk,
   input wire logic rstn,
   // converter and loopback samples
   input wire logic [4*`ACQD_SAMPLE_W-1:0] adc_data,
   input wire logic [`ACQD_SAMPLE_W-1:0] loop_data,
   input wire logic sample_clk_in,
   // external timing pins
   input wire logic external_timing_input,
   input wire logic sync_in,
   // configuration
   input wire logic [`ACQD_SRC_W-1:0] source_sel,
   input wire logic capture_mode,
   input wire logic [`ACQD_LEN_W-1:0] capture_len,
   input wire logic dma_enable,
   // link table write port
   input wire logic link_we,
   input wire logic [`ACQD_LINK_W-1:0] link_addr,
   input wire acqd_pkg::acqd_link_s link_wdata,
   // host stream out
   output logic host_valid,
   input wire logic host_ready,
   output logic [`ACQD_SAMPLE_W-1:0] host_data,
   output logic host_is_meta,
   output acqd_pkg::acqd_meta_s host_meta,
   // status
   output logic [3:0] overload_indicator,
   output logic sample_clock_present,
   output logic dma_busy,
   output logic capture_done,
   output logic [`ACQD_LINK_W-1:0] link_index,
   // timing buses
   output acqd_pkg::acqd_tbus_s adc_tbus,
   output acqd_pkg::acqd_tbus_s dac_tbus
);
   import acqd_pkg::*;
   localparam int MON_CYC = (`ACQD_CLKMON_CYC < 1) ? 1 : `ACQD_CLKMON_CYC;

   function automatic logic [`ACQD_SAMPLE_W-1:0] pick(
      input logic [4*`ACQD_SAMPLE_W-1:0] all, input logic [1:0] idx);
      pick = all[idx*`ACQD_SAMPLE_W +: `ACQD_SAMPLE_W];
   endfunction : pick

   function automatic logic is_ovl(input logic [`ACQD_SAMPLE_W-1:0] s);
      is_ovl = (s == `ACQD_OVL_MAX) || (s == `ACQD_OVL_MIN);
   endfunction : is_ovl

   // pins from outside the clock domain
   logic [2:0] pins_s;
   acqd_sync #(.WIDTH(3)) u_sync (
      .clk(clk),
      .rstn(rstn),
      .d({sample_clk_in, external_timing_input, sync_in}),
      .q(pins_s)
   );
   logic sclk_s;
   logic gate_s;
   logic sync_s;
   assign sclk_s = pins_s[2];
   assign gate_s = pins_s[1];
   assign sync_s = pins_s[0];

   // R11 clock monitor: a toggle within the window keeps presence
   logic sclk_d_reg;
   logic [7:0] mon_reg;
   logic present_reg;
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         sclk_d_reg <= 1'b0;
         mon_reg <= 8'h00;
         present_reg <= 1'b0;
      end else begin
         sclk_d_reg <= sclk_s;
         if (sclk_s != sclk_d_reg) begin
            mon_reg <= 8'h00;
            present_reg <= 1'b1;
         end else if (mon_reg >= 8'(MON_CYC)) begin
            present_reg <= 1'b0;
         end else begin
            mon_reg <= mon_reg + 8'h01;
         end
      end
   end
   assign sample_clock_present = present_reg;

   // R8 timing buses rebuilt from the synchronised pins
   // R9 the outside input serves as gate only; sync comes from sync_in
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         adc_tbus <= '0;
         dac_tbus <= '0;
      end else begin
         adc_tbus <= '{clk: sclk_s, sync: sync_s, gate: gate_s};
         dac_tbus <= '{clk: sclk_s, sync: sync_s, gate: gate_s};
      end
   end

   // R10 overload per converter, stretched so a led can show it
   logic [7:0] ovl_cnt_reg [4];
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         for (int i = 0; i < 4; i++) begin
            ovl_cnt_reg[i] <= 8'h00;
         end
      end else begin
         for (int i = 0; i < 4; i++) begin
            if (is_ovl(pick(adc_data, 2'(i)))) begin
               ovl_cnt_reg[i] <= `ACQD_OVL_HOLD;
            end else if (ovl_cnt_reg[i] != 8'h00) begin
               ovl_cnt_reg[i] <= ovl_cnt_reg[i] - 8'h01;
            end
         end
      end
   end
   always_comb begin
      for (int i = 0; i < 4; i++) begin
         overload_indicator[i] = (ovl_cnt_reg[i] != 8'h00);
      end
   end

   // R1 source selector
   logic [`ACQD_SAMPLE_W-1:0] test_reg;
   logic [`ACQD_SAMPLE_W-1:0] src_sample;
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         test_reg <= '0;
      end else begin
         test_reg <= test_reg + 16'h0001;
      end
   end
   always_comb begin
      if (source_sel == `ACQD_SRC_TEST) begin
         src_sample = test_reg;
      end else if (source_sel == `ACQD_SRC_LOOP) begin
         src_sample = loop_data;
      end else begin
         src_sample = pick(adc_data, source_sel[1:0]);
      end
   end

   // sample stamp counts every sample cycle, cleared by sync
   logic [`ACQD_TS_W-1:0] stamp_reg;
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         stamp_reg <= '0;
      end else if (sync_s) begin
         stamp_reg <= '0;
      end else if (present_reg) begin
         stamp_reg <= stamp_reg + 48'h1;
      end
   end

   // link table and engine state
   acqd_link_s link_mem [LINKS];
   always_ff @(posedge clk) begin
      if (link_we) begin
         link_mem[link_addr] <= link_wdata;
      end
   end
   acqd_link_s cur_link;
   assign cur_link = link_mem[link_index];

   acqd_state_e state_reg;
   logic [`ACQD_LEN_W-1:0] count_reg;
   logic [`ACQD_LEN_W-1:0] cap_cnt_reg;
   logic [`ACQD_LINK_W-1:0] link_reg;
   logic cap_done_reg;
   logic head_ok_reg;
   acqd_meta_s meta_reg;
   assign link_index = link_reg;
   assign capture_done = cap_done_reg;
   assign dma_busy = (state_reg != ACQD_IDLE);

   // R2 bank write: continuous in fifo mode, bounded block in capture mode
   logic wr_ok;
   logic fifo_in_ready;
   logic in_link;
   assign in_link = (state_reg == ACQD_DATA) &&
      (!cur_link.gate_mode || gate_s);
   // R11 no sample is taken without a sample clock
   assign wr_ok = present_reg && in_link &&
      (!capture_mode || !cap_done_reg);

   // R7 bank fifo where outgoing packets are assembled
   logic bank_valid;
   logic bank_ready;
   logic [`ACQD_SAMPLE_W-1:0] bank_data;
   acqd_fifo #(.WIDTH(`ACQD_SAMPLE_W), .DEPTH(FIFO_DEPTH)) u_bank (
      .clk(clk),
      .rstn(rstn),
      .in_valid(wr_ok),
      .in_ready(fifo_in_ready),
      .in_data(src_sample),
      .out_valid(bank_valid),
      .out_ready(bank_ready),
      .out_data(bank_data)
   );
   logic take;
   assign take = wr_ok && fifo_in_ready;

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         cap_cnt_reg <= '0;
         cap_done_reg <= 1'b0;
      end else if (state_reg == ACQD_IDLE) begin
         cap_cnt_reg <= '0;
         cap_done_reg <= 1'b0;
      end else if (take && capture_mode) begin
         cap_cnt_reg <= cap_cnt_reg + 32'h1;
         cap_done_reg <= (cap_cnt_reg + 32'h1 >= capture_len);
      end
   end

   // header fields load one cycle before the header is offered
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         head_ok_reg <= 1'b0;
      end else if (state_reg != ACQD_HEAD) begin
         head_ok_reg <= 1'b0;
      end else if (!bank_valid) begin
         head_ok_reg <= 1'b1;
      end
   end

   // R3 drain the bank toward the host, header first
   // older words leave before the header, so a link never overtakes
   assign host_is_meta = (state_reg == ACQD_HEAD) && head_ok_reg;
   assign host_valid = host_is_meta || bank_valid;
   assign bank_ready = host_ready && !host_is_meta;
   assign host_data = bank_data;
   assign host_meta = meta_reg;

   logic link_end;
   // R5 gate mode ends on gate fall, otherwise the preset length
   assign link_end = cur_link.gate_mode ? !gate_s :
      ((count_reg + {31'h0, take}) >= cur_link.length);

   // R4 link chain engine
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         state_reg <= ACQD_IDLE;
         link_reg <= '0;
         count_reg <= '0;
         meta_reg <= '0;
      end else begin
         case (state_reg)
            ACQD_IDLE: begin
               count_reg <= '0;
               if (dma_enable && present_reg) begin
                  state_reg <= ACQD_HEAD;
               end
            end
            // R6 header with channel, stamp, and length
            ACQD_HEAD: begin
               // fields must stand before the host can take the header
               if (!head_ok_reg && !bank_valid) begin
                  meta_reg <= '{chan: CHAN_ID, stamp: stamp_reg,
                     length: cur_link.length};
               end
               if (head_ok_reg && host_ready) begin
                  state_reg <= ACQD_DATA;
               end
            end
            ACQD_DATA: begin
               if (take) begin
                  count_reg <= count_reg + 32'h1;
               end
               if (link_end && (!cur_link.gate_mode || count_reg != '0)) begin
                  state_reg <= ACQD_CLOSE;
               end
            end
            // R12 record true length; advance to the next link unless this one is last or enable has dropped
            ACQD_CLOSE: begin
               meta_reg.length <= count_reg;
               count_reg <= '0;
               if (cur_link.last || !dma_enable) begin
                  link_reg <= '0;
                  state_reg <= ACQD_IDLE;
               end else begin
                  link_reg <= link_reg + 6'h01;
                  state_reg <= ACQD_HEAD;
               end
            end
            default: begin
               state_reg <= ACQD_IDLE;
            end
         endcase
      end
   end
endmodule : acqd_channel

/* File: verif/acqd_host_model.sv */
// host memory sink for the channel's outgoing stream
`timescale 1ns/100ps
module acqd_host_model (
   // clock and reset
   input wire logic clk,
   input wire logic rstn,
   // stream from the channel
   input wire logic host_valid,
   output logic host_ready,
   // pacing from the bench
   input wire logic stall
);
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         host_ready <= 1'b0;
      end else begin
         host_ready <= stall ? (host_valid & ~host_ready) : 1'b1;
      end
   end
endmodule : acqd_host_model

/* File: verif/acqd_channel_asserts.sv */
// port checker for the acquisition channel
`timescale 1ns/100ps
`include "acqd_consts.svh"
module acqd_channel_asserts #(
   parameter logic [1:0] CHAN_ID = 2'h0,
   parameter int FIFO_DEPTH = 8,
   parameter int LINKS = 64
) (
   // clock and reset
   input wire logic clk,
   input wire logic rstn,
   // inputs
   input wire logic [4*`ACQD_SAMPLE_W-1:0] adc_data,
   input wire logic sample_clk_in,
   input wire logic external_timing_input,
   input wire logic sync_in,
   input wire logic host_ready,
   // outputs
   input wire logic host_valid,
   input wire logic [`ACQD_SAMPLE_W-1:0] host_data,
   input wire logic host_is_meta,
   input wire acqd_pkg::acqd_meta_s host_meta,
   input wire logic [3:0] overload_indicator,
   input wire logic sample_clock_present,
   input wire logic dma_busy,
   input wire acqd_pkg::acqd_tbus_s adc_tbus,
   input wire acqd_pkg::acqd_tbus_s dac_tbus
);
   import acqd_pkg::*;
   default clocking @(posedge clk); endclocking
   default disable iff (!rstn);
   a_ovl_set: assert property (
      adc_data[63:48] == 16'h7FFF && sample_clock_present
      |-> ##[1:4] overload_indicator[3]) else $error("overload not raised");
   a_ovl_hold: assert property (
      $rose(overload_indicator[1]) |=> overload_indicator[1] [*8])
      else $error("overload not held");
   a_clk_lost: assert property (
      $stable(sample_clk_in) [*8] |-> ##[1:8] !sample_clock_present)
      else $error("clock present without clock");
   a_head_first: assert property (
      $rose(dma_busy) && !host_valid |=> host_valid && host_is_meta)
      else $error("transfer not led by header");
   a_word_stand: assert property (
      host_valid && !host_ready |=> host_valid && $stable(host_data)
      && $stable(host_is_meta)) else $error("word dropped before ready");
   a_meta_chan: assert property (
      host_valid && host_is_meta |-> host_meta.chan == CHAN_ID)
      else $error("wrong channel id");
   a_gate_path: assert property (
      $past(rstn, 3) |-> adc_tbus.gate == $past(external_timing_input, 3))
      else $error("gate not on timing bus");
   a_sync_path: assert property (
      $past(rstn, 3) |-> dac_tbus.sync == $past(sync_in, 3))
      else $error("sync not on timing bus");
endmodule : acqd_channel_asserts
bind acqd_channel acqd_channel_asserts #(.CHAN_ID(CHAN_ID),
   .FIFO_DEPTH(FIFO_DEPTH), .LINKS(LINKS)) u_chk (.clk(clk), .rstn(rstn),
   .adc_data(adc_data), .sample_clk_in(sample_clk_in),
   .external_timing_input(external_timing_input), .sync_in(sync_in),
   .host_ready(host_ready), .host_valid(host_valid), .host_data(host_data),
   .host_is_meta(host_is_meta), .host_meta(host_meta),
   .overload_indicator(overload_indicator), .dma_busy(dma_busy),
   .sample_clock_present(sample_clock_present), .adc_tbus(adc_tbus),
   .dac_tbus(dac_tbus));

/* File: verif/acqd_channel_tb.sv */
// self-checking bench for one acquisition channel
`timescale 1ns/100ps
module acqd_channel_tb;
   import acqd_pkg::*;
   typedef struct packed {
      logic [2:0] sel;
      logic [15:0] exp;
      logic chk;
   } acqd_row_s;
   logic clk, rstn, sample_clk_in, external_timing_input, sync_in;
   logic [63:0] adc_data;
   logic [15:0] loop_data, host_data, first;
   logic [2:0] source_sel;
   logic [31:0] capture_len, hlen;
   logic capture_mode, dma_enable, link_we, host_valid, host_ready;
   logic host_is_meta, sample_clock_present, dma_busy, capture_done;
   logic stall, sclk_on, done_seen;
   logic [5:0] link_addr, link_index;
   logic [3:0] overload_indicator;
   acqd_link_s link_wdata;
   acqd_meta_s host_meta;
   acqd_tbus_s adc_tbus, dac_tbus;
   int error_cnt, samples_checked, cyc, n, h;
   acqd_row_s rows [6];
   acqd_channel DUT (.clk(clk), .rstn(rstn), .adc_data(adc_data),
      .loop_data(loop_data), .sample_clk_in(sample_clk_in),
      .external_timing_input(external_timing_input), .sync_in(sync_in),
      .source_sel(source_sel), .capture_mode(capture_mode),
      .capture_len(capture_len), .dma_enable(dma_enable),
      .link_we(link_we), .link_addr(link_addr), .link_wdata(link_wdata),
      .host_valid(host_valid), .host_ready(host_ready),
      .host_data(host_data), .host_is_meta(host_is_meta),
      .host_meta(host_meta), .overload_indicator(overload_indicator),
      .sample_clock_present(sample_clock_present), .dma_busy(dma_busy),
      .capture_done(capture_done), .link_index(link_index),
      .adc_tbus(adc_tbus), .dac_tbus(dac_tbus));
   acqd_host_model u_host (.clk(clk), .rstn(rstn), .host_valid(host_valid),
      .host_ready(host_ready), .stall(stall));
   initial clk = 1'b0;
   always #4 clk = ~clk;
   always @(posedge clk) begin
      cyc++;
      if (sclk_on) sample_clk_in <= ~sample_clk_in;
      if (cyc == 5000) begin
         error_cnt++;
         print_verdict();
      end
   end
   task chk_val(input logic [31:0] got, input logic [31:0] exp);
      samples_checked++;
      if (got !== exp) begin
         error_cnt++;
         $display("[ERR] %0t got %h expected %h", $time, got, exp);
      end
   endtask : chk_val
   task chk_bit(input logic got, input logic exp);
      samples_checked++;
      if (got !== exp) begin
         error_cnt++;
         $display("[ERR] %0t flag %b expected %b", $time, got, exp);
      end
   endtask : chk_bit
   task wr_link(input logic [5:0] a, input logic [31:0] len,
      input logic gm, input logic lst);
      @(posedge clk);
      link_we <= 1'b1;
      link_addr <= a;
      link_wdata <= '{length: len, gate_mode: gm, last: lst};
      @(posedge clk);
      link_we <= 1'b0;
   endtask : wr_link
   // enable held until hk headers seen, so a chain is not cut short
   task xfer(input int hk);
      int t;
      logic fin;
      n = 0;
      h = 0;
      t = 0;
      fin = 1'b0;
      done_seen = 1'b0;
      @(posedge clk);
      dma_enable <= 1'b1;
      while (!fin) begin
         @(negedge clk);
         t++;
         fin = (t >= 600) || (t > 20 && !dma_busy && !host_valid);
         if (capture_done) done_seen = 1'b1;
         if (host_valid && host_ready && host_is_meta) begin
            h++;
            hlen = host_meta.length;
         end else if (host_valid && host_ready) begin
            if (n == 0) first = host_data;
            n++;
         end
         @(posedge clk);
         if (h >= hk) dma_enable <= 1'b0;
      end
      if (t >= 600) begin
         error_cnt++;
         print_verdict();
      end
   endtask : xfer
   task print_verdict();
      $display("checked %0d errors %0d", samples_checked, error_cnt);
      if (error_cnt == 0 && samples_checked > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask : print_verdict
   initial begin
      {rstn, sample_clk_in, external_timing_input, sync_in} = 4'h0;
      {capture_mode, dma_enable, link_we, stall, sclk_on} = 5'h00;
      {source_sel, capture_len, link_addr, link_wdata} = '0;
      adc_data = {16'h7FFF, 16'h0ABC, 16'h8000, 16'h1234};
      loop_data = 16'h0F0F;
      rows[0] = '{3'h0, 16'h1234, 1'b1};
      rows[1] = '{3'h1, 16'h8000, 1'b1};
      rows[2] = '{3'h2, 16'h0ABC, 1'b1};
      rows[3] = '{3'h3, 16'h7FFF, 1'b1};
      rows[4] = '{3'h5, 16'h0F0F, 1'b1};
      rows[5] = '{3'h4, 16'h0000, 1'b0};
      repeat (5) @(posedge clk);
      chk_bit(host_valid, 1'b0);
      rstn <= 1'b1;
      sclk_on <= 1'b1;
      repeat (20) @(posedge clk);
      chk_bit(sample_clock_present, 1'b1);
      chk_val(32'(overload_indicator), 32'hA);
      wr_link(6'h00, 32'h4, 1'b0, 1'b1);
      foreach (rows[i]) begin
         source_sel <= rows[i].sel;
         xfer(1);
         chk_val(32'(n), 32'h4);
         chk_val(32'(h), 32'h1);
         chk_val(hlen, 32'h4);
         if (rows[i].chk) chk_val(32'(first), 32'(rows[i].exp));
      end
      // stalled host takes every other word, words back up in the bank, yet the link still delivers every word
      source_sel <= 3'h0;
      stall <= 1'b1;
      wr_link(6'h00, 32'hC, 1'b0, 1'b1);
      xfer(1);
      chk_val(32'(n), 32'hC);
      chk_val(32'(first), 32'h1234);
      chk_val(hlen, 32'hC);
      stall <= 1'b0;
      wr_link(6'h00, 32'h0, 1'b1, 1'b0);
      wr_link(6'h01, 32'h2, 1'b0, 1'b1);
      external_timing_input <= 1'b1;
      fork
         begin
            repeat (12) @(posedge clk);
            external_timing_input <= 1'b0;
         end
         xfer(2);
      join
      chk_val(32'(h), 32'h2);
      chk_val(hlen, 32'h2);
      chk_bit(n > 2 && n <= 14, 1'b1);
      capture_mode <= 1'b1;
      capture_len <= 32'h5;
      wr_link(6'h00, 32'h5, 1'b0, 1'b1);
      xfer(1);
      chk_bit(done_seen, 1'b1);
      chk_val(32'(n), 32'h5);
      capture_mode <= 1'b0;
      // overload stays lit for its hold time after the code goes away
      adc_data[31:16] <= 16'h0001;
      repeat (100) @(posedge clk);
      chk_bit(overload_indicator[1], 1'b1);
      repeat (200) @(posedge clk);
      chk_bit(overload_indicator[1], 1'b0);
      sclk_on <= 1'b0;
      sync_in <= 1'b1;
      repeat (20) @(posedge clk);
      chk_bit(sample_clock_present, 1'b0);
      chk_bit(dac_tbus.sync, 1'b1);
      print_verdict();
   end
endmodule : acqd_channel_tb
